// ---- logic/srx_section_receiver.sv ----
// Purpose: regenerator section receiver with three-zero-substitution line coder
// Assumes: line_clk is the recovered bit clock; management logic runs on sys_clk
// Notes:   defects cross domains on two-flop synchronisers, events as toggles
// Summary of operation
// - descramble every frame bit except the first overhead row.
// - alignment word is A1 11110110 followed by A2 00101000.
// - frame-synchronous descrambler uses x^7 + x^6 + 1.
// - five consecutive errored alignment words put the framer out of frame.
// - two consecutive good alignment words bring the framer back in frame.
// - hunt for A1A2, then check every frame at the presumed position.
// - frame-loss defect equals out of frame state.
// - frame loss forces all-ones output within 250 us, released likewise.
// - frame-loss defect reported to management only when monitored.
// - compare accepted trace with expected; mismatch raises, match clears defect.
// - trace mismatch forces all-ones within 250 us, released likewise.
// - management can disable the trace-mismatch defect.
// - trace-mismatch defect reported only when monitored.
// - B1 after descrambling checked against BIP-8 of previous raw frame.
// - E1, F1 and D1 to D3 bytes are ignored.
// - count frames with B1 violations each second.
// - flag seconds with any frame-loss or trace-mismatch defect.
// - at each second's close, report count and flag when monitored.
// - monitored state enables all defect reporting.
// - line code is AMI with three zeros replaced by 00V or B0V.
// - encoder keeps an odd pulse count between violations.
// - decode the line on its recovered clock and pass data with clock.
// - signal loss gives all-ones with substitute timing within 250 us.
// - signal-loss defect reported only when monitored.
`timescale 1ns/1ps
`include "srx_defs.svh"

module srx_section_receiver
  import srx_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SRX_SECOND_NS / `SRX_SYS_PERIOD_NS
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         line_clk,
  input  wire logic         line_pos,
  input  wire logic         line_neg,
  input  wire logic         tx_bit,
  output logic              tx_pos,
  output logic              tx_neg,
  output logic              rx_data,
  output logic              rx_frame_start,
  input  wire logic         monitored,
  input  wire logic         tim_enable,
  input  wire logic         exp_trace_wr,
  input  wire logic [127:0] exp_trace_in,
  output srx_defects_t      defect_report,
  output srx_second_t       second_report,
  output logic              second_valid,
  output logic              subst_active,
  output logic              subst_timing
);

  // line-domain reset: asserted at once, released on line_clk
  logic lrst_s1_ff;
  logic lrst_ff;
  always_ff @(posedge line_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lrst_s1_ff <= 1'b1;
      lrst_ff    <= 1'b1;
    end else begin
      lrst_s1_ff <= 1'b0;
      lrst_ff    <= lrst_s1_ff;
    end
  end

  // rail and transmit-bit pins pass two flops
  logic pos_s1_ff, neg_s1_ff, pos_ff, neg_ff, txb_s1_ff, txb_ff;
  always_ff @(posedge line_clk or posedge lrst_ff) begin
    if (lrst_ff) begin
      {pos_s1_ff, neg_s1_ff, pos_ff, neg_ff, txb_s1_ff, txb_ff} <= 6'h00;
    end else begin
      {pos_s1_ff, neg_s1_ff, txb_s1_ff} <= {line_pos, line_neg, tx_bit};
      {pos_ff, neg_ff, txb_ff}          <= {pos_s1_ff, neg_s1_ff, txb_s1_ff};
    end
  end

  // decoder: a same-polarity pulse closes a three-zero group
  logic       pulse, violation, seen_ff, last_pol_ff, cur_bit;
  logic [2:0] dec_sr_ff;
  logic [7:0] zrun_ff;
  logic       los_line;
  assign pulse     = pos_ff | neg_ff;
  assign violation = pulse & seen_ff & (pos_ff == last_pol_ff);
  assign cur_bit   = dec_sr_ff[2];
  assign los_line  = (zrun_ff == `SRX_LOS_ZERO_RUN);
  always_ff @(posedge line_clk or posedge lrst_ff) begin
    if (lrst_ff) begin
      dec_sr_ff   <= 3'h0;
      seen_ff     <= 1'b0;
      last_pol_ff <= 1'b0;
      zrun_ff     <= 8'h00;
    end else begin
      dec_sr_ff <= {dec_sr_ff[1] & ~violation, dec_sr_ff[0] & ~violation, pulse & ~violation};
      if (pulse) begin
        seen_ff     <= 1'b1;
        last_pol_ff <= pos_ff;
        zrun_ff     <= 8'h00;
      end else if (!los_line) begin
        zrun_ff <= zrun_ff + 8'h01;
      end
    end
  end

  // framer
  srx_frm_state_t state_ff;
  logic [12:0]    bit_cnt_ff, nxt_bit_cnt;
  logic [15:0]    faw_sr_ff, faw_word;
  logic [2:0]     miss_ff;
  logic           faw_chk, faw_ok, lof_line;
  assign faw_word    = {faw_sr_ff[14:0], cur_bit};
  assign faw_chk     = (bit_cnt_ff == `SRX_FAW_LAST);
  assign faw_ok      = (faw_word == `SRX_FAW);
  assign nxt_bit_cnt = (bit_cnt_ff == `SRX_FRAME_LAST) ? 13'h0000 : bit_cnt_ff + 13'h0001;
  assign lof_line    = (state_ff != SRX_SYNC);
  always_ff @(posedge line_clk or posedge lrst_ff) begin
    if (lrst_ff) begin
      state_ff   <= SRX_HUNT;
      bit_cnt_ff <= 13'h0000;
      faw_sr_ff  <= 16'h0000;
      miss_ff    <= 3'h0;
    end else begin
      faw_sr_ff  <= faw_word;
      bit_cnt_ff <= nxt_bit_cnt;
      case (state_ff)
        SRX_HUNT: begin
          miss_ff <= 3'h0;
          if (faw_ok) begin
            state_ff   <= SRX_PRESYNC;
            bit_cnt_ff <= `SRX_FAW_NEXT;
          end
        end
        SRX_PRESYNC: begin
          if (faw_chk) begin
            state_ff <= faw_ok ? SRX_SYNC : SRX_HUNT;
          end
        end
        SRX_SYNC: begin
          if (faw_chk) begin
            if (faw_ok) begin
              miss_ff <= 3'h0;
            end else if (miss_ff == `SRX_OOF_MISS_LAST) begin
              state_ff <= SRX_HUNT;
              miss_ff  <= 3'h0;
            end else begin
              miss_ff <= miss_ff + 3'h1;
            end
          end
        end
        default: begin
          state_ff <= SRX_HUNT;
        end
      endcase
    end
  end

  // descrambler, reseeded at the end of the first overhead row
  logic [6:0] scr_ff;
  logic       past_row, dbit;
  assign past_row = (bit_cnt_ff > `SRX_SOH_ROW_LAST);
  assign dbit     = past_row ? (cur_bit ^ scr_ff[6]) : cur_bit;
  always_ff @(posedge line_clk or posedge lrst_ff) begin
    if (lrst_ff) begin
      scr_ff <= `SRX_SCR_SEED;
    end else if (bit_cnt_ff == `SRX_SOH_ROW_LAST) begin
      scr_ff <= `SRX_SCR_SEED;
    end else if (past_row) begin
      scr_ff <= {scr_ff[5:0], scr_ff[6] ^ scr_ff[5]};
    end
  end

  // BIP-8 over raw bits; B1 checked after descrambling; E1/F1/D1-D3 simply pass unread
  logic [7:0] bip_acc_ff, bip_prev_ff, nxt_bip;
  logic       bip_ok_ff, b1_err_ff, b1_any, err_tgl_ff;
  logic [2:0] bit_idx;
  assign bit_idx = bit_cnt_ff[2:0];
  assign b1_any  = ((bit_cnt_ff != `SRX_B1_FIRST) & b1_err_ff) | (dbit ^ bip_prev_ff[bit_idx]);
  always_comb begin
    nxt_bip          = bip_acc_ff;
    nxt_bip[bit_idx] = bip_acc_ff[bit_idx] ^ cur_bit;
  end
  always_ff @(posedge line_clk or posedge lrst_ff) begin
    if (lrst_ff) begin
      bip_acc_ff  <= 8'h00;
      bip_prev_ff <= 8'h00;
      bip_ok_ff   <= 1'b0;
      b1_err_ff   <= 1'b0;
      err_tgl_ff  <= 1'b0;
    end else begin
      if (bit_cnt_ff == `SRX_FRAME_LAST) begin
        bip_prev_ff <= nxt_bip;
        bip_acc_ff  <= 8'h00;
        bip_ok_ff   <= (state_ff == SRX_SYNC);
      end else begin
        bip_acc_ff <= nxt_bip;
        if (state_ff != SRX_SYNC) begin
          bip_ok_ff <= 1'b0;
        end
      end
      if (bit_cnt_ff >= `SRX_B1_FIRST && bit_cnt_ff <= `SRX_B1_LAST) begin
        b1_err_ff <= b1_any;
      end
      if (bit_cnt_ff == `SRX_B1_LAST && state_ff == SRX_SYNC && bip_ok_ff && b1_any) begin
        err_tgl_ff <= ~err_tgl_ff;
      end
    end
  end

  // trace capture and acceptance
  logic [6:0]   j0_sr_ff;
  logic [7:0]   j0_byte;
  logic [127:0] tr_cur_ff, tr_last_ff, tr_acc_ff, cand;
  logic [3:0]   tr_idx_ff;
  logic [1:0]   rep_ff, nxt_rep;
  logic         tr_run_ff, acc_tgl_ff, tr_acc_vld_ff;
  assign j0_byte = {j0_sr_ff, dbit};
  assign cand    = {tr_cur_ff[119:0], j0_byte};
  assign nxt_rep = (cand != tr_last_ff) ? 2'h1 : (rep_ff == `SRX_TRACE_REPEATS) ? rep_ff : rep_ff + 2'h1;
  always_ff @(posedge line_clk or posedge lrst_ff) begin
    if (lrst_ff) begin
      j0_sr_ff      <= 7'h00;
      tr_cur_ff     <= '0;
      tr_last_ff    <= '0;
      tr_acc_ff     <= '0;
      tr_idx_ff     <= 4'h0;
      rep_ff        <= 2'h0;
      tr_run_ff     <= 1'b0;
      acc_tgl_ff    <= 1'b0;
      tr_acc_vld_ff <= 1'b0;
    end else begin
      if (bit_cnt_ff >= `SRX_J0_FIRST && bit_cnt_ff < `SRX_J0_LAST) begin
        j0_sr_ff <= {j0_sr_ff[5:0], dbit};
      end
      if (bit_cnt_ff == `SRX_J0_LAST && state_ff == SRX_SYNC) begin
        tr_cur_ff <= cand;
        if (j0_byte[7]) begin
          tr_idx_ff <= 4'h1;
          tr_run_ff <= 1'b1;
        end else if (tr_run_ff && tr_idx_ff == `SRX_TRACE_LAST_IDX) begin
          tr_run_ff  <= 1'b0;
          tr_last_ff <= cand;
          rep_ff     <= nxt_rep;
          if (nxt_rep == `SRX_TRACE_REPEATS && (cand != tr_acc_ff || !tr_acc_vld_ff)) begin
            tr_acc_ff     <= cand;
            tr_acc_vld_ff <= 1'b1;
            acc_tgl_ff    <= ~acc_tgl_ff;
          end
        end else if (tr_run_ff) begin
          tr_idx_ff <= tr_idx_ff + 4'h1;
        end
      end
    end
  end

  // trace mismatch back into the line domain
  logic tim_ff, tim_l_s1_ff, tim_l_ff, ais_line;
  logic rx_data_ff, rx_frame_ff, hb_tgl_ff, lof_x_ff, los_x_ff;
  assign ais_line = lof_line | los_line | tim_l_ff;
  always_ff @(posedge line_clk or posedge lrst_ff) begin
    if (lrst_ff) begin
      tim_l_s1_ff <= 1'b0;
      tim_l_ff    <= 1'b0;
      rx_data_ff  <= 1'b1;
      rx_frame_ff <= 1'b0;
      hb_tgl_ff   <= 1'b0;
      lof_x_ff    <= 1'b1;
      los_x_ff    <= 1'b0;
    end else begin
      tim_l_s1_ff <= tim_ff;
      tim_l_ff    <= tim_l_s1_ff;
      rx_data_ff  <= ais_line | dbit;
      rx_frame_ff <= (bit_cnt_ff == 13'h0000) & ~lof_line;
      hb_tgl_ff   <= ~hb_tgl_ff;
      lof_x_ff    <= lof_line; // registered so no comparator glitch reaches the sys synchroniser
      los_x_ff    <= los_line;
    end
  end
  assign rx_data        = rx_data_ff;
  assign rx_frame_start = rx_frame_ff;

  // encoder: three-slot look-ahead, substitution tags decided on the third zero
  srx_enc_tag_t [2:0] enc_tag_ff;
  logic [2:0]         enc_bit_ff;
  logic [1:0]         zc_ff;
  logic               enc_pol_ff, enc_par_ff, enc_pulse, enc_out_pol, tx_pos_ff, tx_neg_ff;
  always_comb begin
    enc_pulse   = 1'b0;
    enc_out_pol = ~enc_pol_ff;
    case (enc_tag_ff[2])
      SRX_TAG_NORM: enc_pulse = enc_bit_ff[2];
      SRX_TAG_B:    enc_pulse = ~enc_par_ff;
      SRX_TAG_V: begin
        enc_pulse   = 1'b1;
        enc_out_pol = enc_pol_ff;
      end
      default:      enc_pulse = 1'b0;
    endcase
  end
  always_ff @(posedge line_clk or posedge lrst_ff) begin
    if (lrst_ff) begin
      enc_tag_ff <= {SRX_TAG_NORM, SRX_TAG_NORM, SRX_TAG_NORM};
      enc_bit_ff <= 3'h0;
      zc_ff      <= 2'h0;
      enc_pol_ff <= 1'b0;
      enc_par_ff <= 1'b0;
      tx_pos_ff  <= 1'b0;
      tx_neg_ff  <= 1'b0;
    end else begin
      enc_bit_ff <= {enc_bit_ff[1:0], txb_ff};
      if (!txb_ff && zc_ff == 2'h2) begin
        enc_tag_ff <= {SRX_TAG_B, SRX_TAG_ZERO, SRX_TAG_V};
        zc_ff      <= 2'h0;
      end else begin
        enc_tag_ff <= {enc_tag_ff[1], enc_tag_ff[0], SRX_TAG_NORM};
        zc_ff      <= txb_ff ? 2'h0 : zc_ff + 2'h1;
      end
      tx_pos_ff <= enc_pulse & enc_out_pol;
      tx_neg_ff <= enc_pulse & ~enc_out_pol;
      if (enc_pulse) begin
        enc_pol_ff <= enc_out_pol;
      end
      if (enc_tag_ff[2] == SRX_TAG_V) begin
        enc_par_ff <= 1'b0;
      end else if (enc_tag_ff[2] == SRX_TAG_NORM && enc_bit_ff[2]) begin
        enc_par_ff <= ~enc_par_ff;
      end
    end
  end
  assign tx_pos = tx_pos_ff;
  assign tx_neg = tx_neg_ff;

  // sys domain: synchronise defect levels and event toggles
  logic lof_s1_ff, lof_s_ff, los_s1_ff, los_s_ff;
  logic err_s1_ff, err_s2_ff, err_s3_ff, acc_s1_ff, acc_s2_ff, acc_s3_ff;
  logic hb_s1_ff, hb_s2_ff, hb_s3_ff, err_evt, acc_evt, los_sys;
  logic [7:0] wd_cnt_ff;
  assign err_evt = err_s2_ff ^ err_s3_ff;
  assign acc_evt = acc_s2_ff ^ acc_s3_ff;
  assign los_sys = los_s_ff | (wd_cnt_ff == `SRX_WD_CYCLES);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {lof_s1_ff, lof_s_ff, los_s1_ff, los_s_ff} <= 4'hf;
      {err_s1_ff, err_s2_ff, err_s3_ff}          <= 3'h0;
      {acc_s1_ff, acc_s2_ff, acc_s3_ff}          <= 3'h0;
      {hb_s1_ff, hb_s2_ff, hb_s3_ff}             <= 3'h0;
      wd_cnt_ff                                  <= 8'h00;
    end else begin
      {lof_s1_ff, lof_s_ff} <= {lof_x_ff, lof_s1_ff};
      {los_s1_ff, los_s_ff} <= {los_x_ff, los_s1_ff};
      {err_s1_ff, err_s2_ff, err_s3_ff} <= {err_tgl_ff, err_s1_ff, err_s2_ff};
      {acc_s1_ff, acc_s2_ff, acc_s3_ff} <= {acc_tgl_ff, acc_s1_ff, acc_s2_ff};
      {hb_s1_ff, hb_s2_ff, hb_s3_ff}    <= {hb_tgl_ff, hb_s1_ff, hb_s2_ff};
      if (hb_s2_ff != hb_s3_ff) begin
        wd_cnt_ff <= 8'h00;
      end else if (wd_cnt_ff != `SRX_WD_CYCLES) begin
        wd_cnt_ff <= wd_cnt_ff + 8'h01; // dead line clock counts as loss of signal
      end
    end
  end

  // expected trace register and mismatch defect
  logic [127:0] exp_ff, acc_sys_ff;
  logic         acc_vld_sys_ff;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exp_ff         <= '0;
      acc_sys_ff     <= '0;
      acc_vld_sys_ff <= 1'b0;
      tim_ff         <= 1'b0;
    end else begin
      if (exp_trace_wr) begin
        exp_ff <= exp_trace_in;
      end
      if (acc_evt) begin
        acc_sys_ff     <= tr_acc_ff; // held stable since the line_clk edge that flipped the toggle
        acc_vld_sys_ff <= 1'b1;
      end
      tim_ff <= tim_enable & acc_vld_sys_ff & (acc_sys_ff != exp_ff);
    end
  end

  // one-second interval, counters and gated reports
  logic [31:0]  sec_cnt_ff;
  logic [12:0]  ebc_ff, nxt_ebc;
  logic         ds_ff, nxt_ds, sec_end;
  srx_defects_t rep_def_ff;
  srx_second_t  sec_rep_ff;
  logic         sec_vld_ff;
  logic [1:0]   sub_div_ff;
  logic         sub_act_ff;
  assign sec_end = (sec_cnt_ff == 32'(SEC_CYCLES - 1));
  assign nxt_ebc = (err_evt && ebc_ff != `SRX_EBC_MAX) ? ebc_ff + 13'h0001 : ebc_ff;
  assign nxt_ds  = ds_ff | lof_s_ff | tim_ff;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_cnt_ff <= 32'h0000_0000;
      ebc_ff     <= 13'h0000;
      ds_ff      <= 1'b0;
      sec_rep_ff <= '0;
      sec_vld_ff <= 1'b0;
      rep_def_ff <= '0;
    end else begin
      sec_cnt_ff <= sec_end ? 32'h0000_0000 : sec_cnt_ff + 32'h0000_0001;
      ebc_ff     <= sec_end ? 13'h0000 : nxt_ebc;
      ds_ff      <= sec_end ? 1'b0 : nxt_ds;
      sec_vld_ff <= sec_end & monitored;
      if (sec_end && monitored) begin
        sec_rep_ff <= '{ebc: nxt_ebc, ds: nxt_ds};
      end
      rep_def_ff <= '{signal_loss_defect: los_sys & monitored, frame_loss_defect: lof_s_ff & monitored, tim: tim_ff & monitored};
    end
  end

  // substitute timing reference while the line is lost
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sub_div_ff <= 2'h0;
      sub_act_ff <= 1'b0;
    end else begin
      sub_div_ff <= sub_div_ff + 2'h1;
      sub_act_ff <= los_sys;
    end
  end
  assign subst_timing  = sub_div_ff[1];
  assign subst_active  = sub_act_ff;
  assign defect_report = rep_def_ff;
  assign second_report = sec_rep_ff;
  assign second_valid  = sec_vld_ff;

  // checks on the line side
  chk_oof_entry: assert property (@(posedge line_clk) disable iff (lrst_ff)
    (state_ff == SRX_SYNC && faw_chk && !faw_ok && miss_ff == 3'h4) |=> (state_ff == SRX_HUNT))
    else $error("framer did not leave sync after fifth bad alignment word");
  chk_inframe_entry: assert property (@(posedge line_clk) disable iff (lrst_ff)
    (state_ff == SRX_PRESYNC && faw_chk && faw_ok) |=> (state_ff == SRX_SYNC) && !lof_line)
    else $error("framer did not enter sync on second good alignment word");
  chk_ais_output: assert property (@(posedge line_clk) disable iff (lrst_ff)
    (lof_line || los_line) [*2] |-> rx_data_ff)
    else $error("output not all ones during frame or signal loss");
  chk_scr_seed: assert property (@(posedge line_clk) disable iff (lrst_ff)
    (bit_cnt_ff == `SRX_SOH_ROW_LAST && !lof_line) |=> (scr_ff == `SRX_SCR_SEED) && past_row)
    else $error("descrambler not seeded at end of first row");
  chk_decode_violation: assert property (@(posedge line_clk) disable iff (lrst_ff)
    violation |=> (dec_sr_ff == 3'h0))
    else $error("violation did not clear its zero group");
  chk_enc_violation: assert property (@(posedge line_clk) disable iff (lrst_ff)
    (enc_tag_ff[2] == SRX_TAG_V) |=> ((tx_pos_ff | tx_neg_ff) && tx_pos_ff == $past(enc_pol_ff)))
    else $error("violation pulse polarity wrong");

  // checks on the management side
  chk_tim_disabled: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !tim_enable |=> !tim_ff ##1 !rep_def_ff.tim)
    else $error("trace mismatch raised while disabled");
  chk_second_report: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sec_end && monitored) |=> sec_vld_ff && sec_rep_ff.ebc == $past(nxt_ebc) && ebc_ff == 13'h0000)
    else $error("one-second report missing or wrong");
  chk_ds_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (lof_s_ff && !sec_end) |=> ds_ff)
    else $error("defect second not flagged on frame loss");
  chk_report_gating: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !monitored |=> (rep_def_ff == 3'h0) && !sec_vld_ff)
    else $error("report made while not monitored");

endmodule

// ---- logic/srx_defs.svh ----
// Purpose: constants for the sub-STM-1 section receiver and line coder
// Assumes: bit-serial processing on the recovered line clock, 810-byte frame
// Notes:   bit positions count from the first A1 bit of the frame, MSB first
`ifndef SRX_DEFS_SVH
`define SRX_DEFS_SVH
// frame alignment word: A1 then A2
`define SRX_FAW             16'hf628
// frame geometry in bits (9 x 90 bytes)
`define SRX_FRAME_LAST      13'h194f
`define SRX_FAW_LAST        13'h000f
`define SRX_FAW_NEXT        13'h0010
`define SRX_SOH_ROW_LAST    13'h0017
`define SRX_J0_FIRST        13'h0010
`define SRX_J0_LAST         13'h0017
`define SRX_B1_FIRST        13'h02d0
`define SRX_B1_LAST         13'h02d7
// descrambler seed, loaded before the first scrambled bit
`define SRX_SCR_SEED        7'h7f
// framer thresholds
`define SRX_OOF_MISS_LAST   3'h4
// trace acceptance: 16 bytes, three equal multiframes
`define SRX_TRACE_LAST_IDX  4'hf
`define SRX_TRACE_REPEATS   2'h3
// loss of signal: zero symbols in a row, and dead-clock watchdog on sys_clk
`define SRX_LOS_ZERO_RUN    8'h40
`define SRX_WD_CYCLES       8'h40
// timing
`define SRX_SYS_PERIOD_NS   32'h0000_0005
`define SRX_SECOND_NS       32'h3b9a_ca00
`define SRX_DEFECT_RESP_NS  32'h0003_d090
`define SRX_EBC_MAX         13'h1fff
`endif

// ---- logic/srx_pkg.sv ----
// Purpose: types shared by the section receiver
// Assumes: constants live in srx_defs.svh
// Notes:   structs carry the management reports
package srx_pkg;
  typedef enum logic [1:0] {
    SRX_HUNT    = 2'b00,
    SRX_PRESYNC = 2'b01,
    SRX_SYNC    = 2'b10
  } srx_frm_state_t;

  typedef enum logic [1:0] {
    SRX_TAG_NORM = 2'b00,
    SRX_TAG_B    = 2'b01,
    SRX_TAG_ZERO = 2'b10,
    SRX_TAG_V    = 2'b11
  } srx_enc_tag_t;

  typedef struct packed {
    logic signal_loss_defect;
    logic frame_loss_defect;
    logic tim;
  } srx_defects_t;

  typedef struct packed {
    logic [12:0] ebc;
    logic        ds;
  } srx_second_t;
endpackage

// ---- sim/srx_far_tx.sv ----
// Purpose: far-end transmitter model driving framed three-zero-substituted symbols
// Assumes: free-running 80 ns line clock, J0 byte fixed at 80h
// Notes:   payload is all zeros before scrambling
`timescale 1ns/1ps
`include "srx_defs.svh"
module srx_far_tx (
  output logic       line_clk,
  output logic       line_pos,
  output logic       line_neg,
  output logic       fstart,
  output logic [7:0] b1_field,
  input  wire logic  faw_bad,
  input  wire logic  b1_bad,
  input  wire logic  quiet
);
  logic [15:0] faw_w = `SRX_FAW;
  logic [6:0]  sc    = 7'h7f;
  logic [7:0]  bip   = 8'h00;
  logic [2:0]  q     = 3'b111;
  logic [5:0]  seq   = 6'h00;
  logic [1:0]  sym;
  logic        pol   = 1'b0;
  logic        nb;
  int          bc    = 0;
  int          sub   = 0;
  int          npul  = 0;
  // line clock, phase unrelated to sys_clk
  initial begin
    {line_pos, line_neg, fstart, b1_field} = 11'h000;
    line_clk = 1'b0;
    #13;
    forever #40 line_clk = ~line_clk;
  end
  // frame bits, scrambling, parity, then line coding
  always @(posedge line_clk) begin
    if (bc < 24)
      nb = (bc < 16) ? faw_w[15 - bc] ^ (faw_bad && bc == 0) : (bc == 16);
    else
      nb = sc[6] ^ (bc > 719 && bc < 728 && (b1_field[727 - bc] ^ b1_bad));
    if (bc > 23)
      sc = {sc[5:0], sc[6] ^ sc[5]};
    bip[7 - bc % 8] ^= nb;
    fstart <= (bc == 0);
    bc = (bc == 6479) ? 0 : bc + 1;
    if (bc == 0) begin
      b1_field = bip;
      bip = 8'h00;
      sc = 7'h7f;
    end
    q = {q[1:0], nb};
    if (sub == 0 && q == 3'b000) begin
      seq = npul[0] ? {4'h0, pol, ~pol} : {~pol, pol, 2'b00, ~pol, pol};
      pol = npul[0] ? pol : ~pol;
      npul = 0;
      sub = 3;
    end
    if (sub > 0) begin
      sym = seq[5:4];
      seq = seq << 2;
      sub--;
    end else begin
      pol = pol ^ q[2];
      npul += q[2];
      sym = q[2] ? {pol, ~pol} : 2'b00;
    end
    line_pos <= sym[1] & ~quiet;
    line_neg <= sym[0] & ~quiet;
  end
endmodule

// ---- sim/test_srx_section_receiver.sv ----
// Purpose: self-checking bench for the section receiver
// Assumes: far-end model supplies line clock and framed symbols
// Notes:   short second interval keeps reports frequent
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
  $display("BAD %s exp %0h seen %0h", nm, ex, got); end end
module test_srx_section_receiver;
  logic sys_clk = 1'b0, sys_rst = 1'b1, tx_bit = 1'b0, monitored = 1'b0, tim_en = 1'b1, st;
  logic faw_bad = 1'b0, b1_bad = 1'b0, quiet = 1'b0, enc_on = 1'b0, vs = 1'b0, lp, lv;
  logic line_clk, line_pos, line_neg, fstart, tx_pos, tx_neg, rx_data, rx_frame_start;
  logic second_valid, subst_active, subst_timing;
  logic [7:0]            b1_field;
  logic [31:0]           pat = 32'h8010_0c45;
  srx_pkg::srx_defects_t defect_report;
  srx_pkg::srx_second_t  second_report;
  int num_errors = 0;
  int checks_done = 0;
  integer ebc_sum = 0, ds_sum = 0, ones, ex_ones;
  int zr = 0, np = 0, ti = 0;
  srx_far_tx i_far (.line_clk(line_clk), .line_pos(line_pos), .line_neg(line_neg), .fstart(fstart),
    .b1_field(b1_field), .faw_bad(faw_bad), .b1_bad(b1_bad), .quiet(quiet));
  srx_section_receiver #(.SEC_CYCLES(40000)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .line_clk(line_clk), .line_pos(line_pos), .line_neg(line_neg), .tx_bit(tx_bit), .tx_pos(tx_pos),
    .tx_neg(tx_neg), .rx_data(rx_data), .rx_frame_start(rx_frame_start), .monitored(monitored),
    .tim_enable(tim_en), .exp_trace_wr(1'b0), .exp_trace_in(128'h0), .defect_report(defect_report),
    .second_report(second_report), .second_valid(second_valid), .subst_active(subst_active),
    .subst_timing(subst_timing));
  initial forever #2.5 sys_clk = ~sys_clk;
  // sum each one-second report
  always @(negedge sys_clk) begin
    if (second_valid) begin
      ebc_sum += second_report.ebc;
      ds_sum += second_report.ds;
    end
  end
  // encoder stimulus and line code watch
  always @(negedge line_clk) begin
    tx_bit <= pat[ti % 32];
    ti++;
    if (enc_on && (tx_pos || tx_neg)) begin
      `CHK("rail clash", 1'b0, tx_pos & tx_neg)
      if (tx_pos === lp) begin
        if (vs) begin
          `CHK("v polarity", ~lv, tx_pos)
          `CHK("odd pulses", 1'b1, np[0])
        end
        vs = 1'b1;
        lv = tx_pos;
        np = 0;
      end else
        np++;
      lp = tx_pos;
      zr = 0;
    end else if (enc_on) begin
      zr++;
      `CHK("zero run", 1'b1, zr < 3)
    end
  end
  task automatic frames(input int n);
    repeat (n) @(posedge fstart);
    @(negedge sys_clk);
  endtask
  // count ones of rx_data, optionally from the next frame start
  task automatic count_ones(input int n, input logic at_fs);
    int k;
    k = 0;
    ones = 0;
    while (at_fs && rx_frame_start !== 1'b1 && k < 20000) begin
      @(negedge line_clk);
      k++;
    end
    if (k >= 20000) num_errors++;
    ex_ones = 9 + $countones(b1_field);
    repeat (n) begin
      ones += rx_data;
      @(negedge line_clk);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20_000_000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (60) @(negedge sys_clk);
    `CHK("reset out", 5'h10, {rx_data, defect_report, tx_pos})
    sys_rst = 1'b0;
    monitored = 1'b1;
    frames(4);
    enc_on = 1'b1;
    `CHK("in frame", 3'h0, defect_report)
    count_ones(6480, 1'b1);
    `CHK("frame ones", ex_ones, ones)
    ebc_sum = 0;
    b1_bad = 1'b1;
    frames(2);
    b1_bad = 1'b0;
    frames(3);
    `CHK("errored blocks", 2, ebc_sum)
    ds_sum = 0;
    faw_bad = 1'b1;
    frames(6);
    `CHK("frame loss", 3'h2, defect_report)
    count_ones(400, 1'b0);
    `CHK("all ones lof", 400, ones)
    monitored = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("unmonitored", 3'h0, defect_report)
    monitored = 1'b1;
    faw_bad = 1'b0;
    frames(4);
    `CHK("lof cleared", 3'h0, defect_report)
    `CHK("defect second", 1'b1, ds_sum > 0)
    quiet = 1'b1;
    count_ones(200, 1'b0);
    `CHK("signal loss", 2'h3, {defect_report.signal_loss_defect, subst_active})
    count_ones(64, 1'b0);
    `CHK("all ones los", 64, ones)
    st = subst_timing;
    repeat (2) @(negedge sys_clk);
    `CHK("subst timing", ~st, subst_timing)
    quiet = 1'b0;
    frames(4);
    `CHK("los cleared", 3'h0, defect_report)
    print_verdict();
  end
endmodule
